/* shared/pait_regs.vh */
// Notes on behaviour
// - system-clock prescaler is 13-bit binary counter, advancing once per system clock.
// - chip reset clears system-clock prescaler; counting starts on return to active.
// - in standby, watch or subactive, system-clock prescaler halts and reads zero.
// - system-clock prescaler has no software-visible register location.
// - system-clock taps shared by several consumers, each selecting its own ratio.
// - subclock prescaler is 5-bit counter advanced by subclock edges.
// - chip reset clears subclock prescaler; counting starts on return to active.
// - subclock prescaler keeps counting in low-power states while subclock runs.
// - writing ones to source-select and top clock-select bits resets subclock prescaler.
// - subclock prescaler can drive the 8-bit timer as a time base.
// - timer is 8-bit counter, interval timer when fed from system-clock prescaler.
// - interval mode taps divide by 8192,4096,2048,512,256,128,32,8.
// - time-base mode gives 2 s, 1 s, 0.5 s, 125 ms overflow periods.
// - counter overflow raises an interrupt request.
// - mode bit 3 clear selects system-clock prescaler, set selects subclock prescaler.
// - time-base period bits 00=2 s, 01=1 s, 10=0.5 s, 11=125 ms.
// - count past all ones wraps to zero, sets request flag; interrupt needs enable.
// - both upper mode bits set hold subclock prescaler and counter cleared, stopped.
`ifndef PAIT_REGS_VH
`define PAIT_REGS_VH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define PAIT_IDX_MODE        16'hffc0
`define PAIT_IDX_COUNT       16'hffc1
`define PAIT_IDX_STATUS      16'hffc2
`define PAIT_IDX_MASK        16'hffc3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PAIT_RST_MODE        8'hf0
`define PAIT_RST_COUNT       8'h00
`define PAIT_RST_STATUS      8'h00
`define PAIT_RST_MASK        8'h00
`define PAIT_MODE_RSVD_ONES  8'hf0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PAIT_SOURCE_SELECT_BIT     3
`define PAIT_CLOCK_SELECT_HIGH_BIT 2
`define PAIT_PERIOD_SELECT_HI      1
`define PAIT_PERIOD_SELECT_LO      0
`define PAIT_OVERFLOW_BIT          0

// ----------------------------------------------------------------
// tap indices, tap i pulses once every 2**(i+1) advances
// ----------------------------------------------------------------
`define PAIT_PSS_TAP_DIV8192 4'hc
`define PAIT_PSS_TAP_DIV4096 4'hb
`define PAIT_PSS_TAP_DIV2048 4'ha
`define PAIT_PSS_TAP_DIV512  4'h8
`define PAIT_PSS_TAP_DIV256  4'h7
`define PAIT_PSS_TAP_DIV128  4'h6
`define PAIT_PSS_TAP_DIV32   4'h4
`define PAIT_PSS_TAP_DIV8    4'h2
`define PAIT_PSW_TAP_2S      3'h4
`define PAIT_PSW_TAP_1S      3'h3
`define PAIT_PSW_TAP_500MS   3'h2
`define PAIT_PSW_TAP_125MS   3'h0

`endif

/* hdl/pait_sync.v */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// two-stage synchroniser for a level from outside the clock domain
// ----------------------------------------------------------------
module pait_sync (
    input  wire ref_clk,
    input  wire nrst,
    input  wire async_in,
    output wire sync_out
);

    reg stage_one;
    reg stage_two;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stage_one <= 1'b0;
            stage_two <= 1'b0;
        end else begin
            stage_one <= async_in;
            stage_two <= stage_one;
        end
    end

    assign sync_out = stage_two;

endmodule

`default_nettype wire

/* hdl/pait_prescaler.v */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// free-running binary prescaler with per-bit tap pulses
// ----------------------------------------------------------------
module pait_prescaler #(
    parameter WIDTH = 13
) (
    input  wire             ref_clk,
    input  wire             nrst,
    input  wire             advance,
    input  wire             clear,
    output reg  [WIDTH-1:0] count,
    output wire [WIDTH-1:0] tap_pulse
);

    // clear beats advance so a held clear keeps the count at zero
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count <= {WIDTH{1'b0}};
        end else if (clear) begin
            count <= {WIDTH{1'b0}};
        end else if (advance) begin
            count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // tap i carries out of bit i: one pulse per 2**(i+1) advances
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_tap
            assign tap_pulse[i] = advance & ~clear & (&count[i:0]);
        end
    endgenerate

endmodule

`default_nettype wire

/* hdl/pait_timer.v */
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

`include "pait_regs.vh"

// ----------------------------------------------------------------
// prescalers and 8-bit interval / time-base timer, ahb-lite slave
// ----------------------------------------------------------------
module pait_timer #(
    parameter HADDR_W = 18,
    parameter PSS_W   = 13,
    parameter PSW_W   = 5,
    parameter CNT_W   = 8
) (
    input  wire               ref_clk,
    input  wire               nrst,
    input  wire               hsel,
    input  wire [HADDR_W-1:0] haddr,
    input  wire [1:0]         htrans,
    input  wire               hwrite,
    input  wire [2:0]         hsize,
    input  wire [31:0]        hwdata,
    input  wire               hready,
    output wire               hreadyout,
    output wire               hresp,
    output reg  [31:0]        hrdata,
    input  wire               low_power_mode,
    input  wire               subclk,
    output wire [PSS_W-1:0]   sysclk_taps,
    output wire [PSW_W-1:0]   subclk_taps,
    output reg                timer_overflow,
    output wire               overflow_request_flag,
    output wire               irq
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    reg  [3:0]       timer_mode_select;
    reg  [CNT_W-1:0] timer_count_value;
    reg  [7:0]       irq_status;
    reg  [7:0]       irq_mask;

    reg              dp_active;
    reg              dp_write;
    reg  [15:0]      dp_index;

    reg              subclk_prev;
    wire             subclk_sync;
    wire             subclk_edge;

    wire [PSS_W-1:0] pss_count;
    wire [PSS_W-1:0] pss_taps;
    wire [PSW_W-1:0] psw_count;
    wire [PSW_W-1:0] psw_taps;

    wire             source_select_bit;
    wire             clock_select_high_bit;
    wire             period_select_hi;
    wire             period_select_lo;
    wire             init_hold;

    reg  [3:0]       pss_tap_sel;
    reg  [2:0]       psw_tap_sel;
    wire             count_tick;
    wire             overflow_event;

    wire             addr_phase;
    wire [15:0]      ap_index;
    wire             wr_mode;
    wire             wr_status;
    wire             wr_mask;
    reg  [31:0]      next_rdata;
    reg  [3:0]       next_mode;
    wire [7:0]       status_clear;
    wire [7:0]       status_set;

    // only the writable low nibble of the reset value is stored
    localparam [7:0] MODE_RST_BYTE = `PAIT_RST_MODE;

    // ----------------------------------------------------------------
    // mode field decode
    // ----------------------------------------------------------------
    assign source_select_bit     = timer_mode_select[`PAIT_SOURCE_SELECT_BIT];
    assign clock_select_high_bit = timer_mode_select[`PAIT_CLOCK_SELECT_HIGH_BIT];
    assign period_select_hi      = timer_mode_select[`PAIT_PERIOD_SELECT_HI];
    assign period_select_lo      = timer_mode_select[`PAIT_PERIOD_SELECT_LO];

    // both upper bits set: initialise and hold
    assign init_hold = source_select_bit & clock_select_high_bit;

    // ----------------------------------------------------------------
    // subclock edge detect
    // ----------------------------------------------------------------
    // subclock is far slower than ref_clk, so a rising edge of the
    // synchronised level marks exactly one subclock cycle
    pait_sync u_subclk_sync (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .async_in (subclk),
        .sync_out (subclk_sync)
    );

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            subclk_prev <= 1'b0;
        end else begin
            subclk_prev <= subclk_sync;
        end
    end

    assign subclk_edge = subclk_sync & ~subclk_prev;

    // ----------------------------------------------------------------
    // system-clock prescaler
    // ----------------------------------------------------------------
    // the system clock stands still in low-power states, so the
    // count is held at zero there and restarts when active again
    pait_prescaler #(
        .WIDTH (PSS_W)
    ) u_sysclk_prescaler (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .advance   (~low_power_mode),
        .clear     (low_power_mode),
        .count     (pss_count),
        .tap_pulse (pss_taps)
    );

    // count itself is never mapped to the bus; only taps leave
    assign sysclk_taps = pss_taps;

    // ----------------------------------------------------------------
    // subclock prescaler
    // ----------------------------------------------------------------
    // advances in every power state as long as subclock edges arrive
    pait_prescaler #(
        .WIDTH (PSW_W)
    ) u_subclk_prescaler (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .advance   (subclk_edge),
        .clear     (init_hold),
        .count     (psw_count),
        .tap_pulse (psw_taps)
    );

    assign subclk_taps = psw_taps;

    // ----------------------------------------------------------------
    // count source selection
    // ----------------------------------------------------------------
    always @* begin
        case ({clock_select_high_bit, period_select_hi, period_select_lo})
            3'h0: pss_tap_sel = `PAIT_PSS_TAP_DIV8192;
            3'h1: pss_tap_sel = `PAIT_PSS_TAP_DIV4096;
            3'h2: pss_tap_sel = `PAIT_PSS_TAP_DIV2048;
            3'h3: pss_tap_sel = `PAIT_PSS_TAP_DIV512;
            3'h4: pss_tap_sel = `PAIT_PSS_TAP_DIV256;
            3'h5: pss_tap_sel = `PAIT_PSS_TAP_DIV128;
            3'h6: pss_tap_sel = `PAIT_PSS_TAP_DIV32;
            3'h7: pss_tap_sel = `PAIT_PSS_TAP_DIV8;
            default: pss_tap_sel = `PAIT_PSS_TAP_DIV8192;
        endcase
    end

    // with a 4096 Hz subclock, 256 counts of these taps give the periods
    always @* begin
        case ({period_select_hi, period_select_lo})
            2'h0: psw_tap_sel = `PAIT_PSW_TAP_2S;
            2'h1: psw_tap_sel = `PAIT_PSW_TAP_1S;
            2'h2: psw_tap_sel = `PAIT_PSW_TAP_500MS;
            2'h3: psw_tap_sel = `PAIT_PSW_TAP_125MS;
            default: psw_tap_sel = `PAIT_PSW_TAP_2S;
        endcase
    end

    // no tick while held; the system-clock side needs no hold because
    // bit 3 clear already leaves the initialise state
    assign count_tick = source_select_bit
                      ? (~init_hold & psw_taps[psw_tap_sel])
                      : pss_taps[pss_tap_sel];

    assign overflow_event = count_tick & (&timer_count_value);

    // ----------------------------------------------------------------
    // 8-bit timer counter
    // ----------------------------------------------------------------
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            timer_count_value <= `PAIT_RST_COUNT;
            timer_overflow    <= 1'b0;
        end else begin
            timer_overflow <= overflow_event;
            if (init_hold) begin
                timer_count_value <= `PAIT_RST_COUNT;
            end else if (count_tick) begin
                // wraps from all ones to zero and keeps counting
                timer_count_value <= timer_count_value + 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // ahb-lite address and data phase
    // ----------------------------------------------------------------
    // always zero wait states; the master idles during a write data
    // phase, so a following read always sees the new value
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    assign addr_phase = hsel & htrans[1] & hready;
    assign ap_index   = haddr[17:2];

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            dp_active <= 1'b0;
            dp_write  <= 1'b0;
            dp_index  <= 16'h0000;
        end else if (hready) begin
            dp_active <= addr_phase;
            dp_write  <= addr_phase & hwrite;
            dp_index  <= ap_index;
        end
    end

    assign wr_mode   = dp_active & dp_write & (dp_index == `PAIT_IDX_MODE);
    assign wr_status = dp_active & dp_write & (dp_index == `PAIT_IDX_STATUS);
    assign wr_mask   = dp_active & dp_write & (dp_index == `PAIT_IDX_MASK);

    // ----------------------------------------------------------------
    // read data, sampled in the address phase
    // ----------------------------------------------------------------
    always @* begin
        next_rdata = 32'h0000_0000;
        case (ap_index)
            `PAIT_IDX_MODE:   next_rdata = {24'h00_0000, `PAIT_MODE_RSVD_ONES | {4'h0, timer_mode_select}};
            `PAIT_IDX_COUNT:  next_rdata = {24'h00_0000, timer_count_value};
            `PAIT_IDX_STATUS: next_rdata = {24'h00_0000, irq_status};
            `PAIT_IDX_MASK:   next_rdata = {24'h00_0000, irq_mask};
            default:          next_rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_phase & ~hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // mode register
    // ----------------------------------------------------------------
    // upper nibble is fixed ones and ignores writes
    always @* begin
        next_mode = timer_mode_select;
        if (wr_mode) begin
            next_mode = hwdata[3:0];
        end
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            timer_mode_select <= MODE_RST_BYTE[3:0];
        end else begin
            timer_mode_select <= next_mode;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status and mask
    // ----------------------------------------------------------------
    assign status_clear = wr_status ? hwdata[7:0] : 8'h00;
    assign status_set   = {7'h00, overflow_event};

    // set wins over a write-one clear in the same cycle
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_status <= `PAIT_RST_STATUS;
            irq_mask   <= `PAIT_RST_MASK;
        end else begin
            irq_status <= (irq_status & ~status_clear) | status_set;
            if (wr_mask) begin
                irq_mask <= {7'h00, hwdata[`PAIT_OVERFLOW_BIT]};
            end
        end
    end

    assign overflow_request_flag = irq_status[`PAIT_OVERFLOW_BIT];
    assign irq                   = |(irq_status & irq_mask);

endmodule

`default_nettype wire

/* testbench/pait_timer_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// port checker for the prescaler and timer block
// ----------------------------------------------------------------
module pait_timer_monitor #(
    parameter HADDR_W = 18,
    parameter PSS_W   = 13,
    parameter PSW_W   = 5,
    parameter CNT_W   = 8
) (
    input wire logic               ref_clk,
    input wire logic               nrst,
    input wire logic               hsel,
    input wire logic [HADDR_W-1:0] haddr,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic [2:0]         hsize,
    input wire logic [31:0]        hwdata,
    input wire logic               hready,
    input wire logic               hreadyout,
    input wire logic               hresp,
    input wire logic [31:0]        hrdata,
    input wire logic               low_power_mode,
    input wire logic               subclk,
    input wire logic [PSS_W-1:0]   sysclk_taps,
    input wire logic [PSW_W-1:0]   subclk_taps,
    input wire logic               timer_overflow,
    input wire logic               overflow_request_flag,
    input wire logic               irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // div-8 tap stays low for the seven cycles between its pulses
    sequence s_div8_quiet;
        !sysclk_taps[2] [*7];
    endsequence
    // two cycles in, the cleared prescaler can no longer pulse
    sequence s_low_power;
        low_power_mode [*2];
    endsequence

    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    AST_PSS_PERIOD: assert property (sysclk_taps[2] |=> s_div8_quiet)
        else $error("div-8 tap pulsed early");
    AST_PSS_NEST: assert property (sysclk_taps[PSS_W-1] |-> sysclk_taps[0])
        else $error("top tap without lowest tap");
    AST_PSS_STOP: assert property (s_low_power |-> sysclk_taps == '0)
        else $error("system taps pulse in low power");
    AST_PSS_WAKE: assert property ($fell(low_power_mode) |-> ##[1:4] sysclk_taps[0])
        else $error("system prescaler did not resume");
    AST_OVF_PULSE: assert property (timer_overflow |=> !timer_overflow)
        else $error("overflow pulse longer than one cycle");
    AST_OVF_FLAG: assert property (timer_overflow |-> overflow_request_flag)
        else $error("overflow without request flag");
    AST_IRQ_FLAG: assert property (irq |-> overflow_request_flag)
        else $error("interrupt without request flag");
    AST_PSW_NEST: assert property (subclk_taps[PSW_W-1] |-> subclk_taps[0])
        else $error("subclock top tap without lowest tap");
    AST_PSW_PULSE: assert property (subclk_taps[0] |=> !subclk_taps[0])
        else $error("subclock tap longer than one cycle");
endmodule

bind pait_timer pait_timer_monitor #(.HADDR_W(HADDR_W), .PSS_W(PSS_W), .PSW_W(PSW_W),
    .CNT_W(CNT_W)) u_mon (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .low_power_mode(low_power_mode),
    .subclk(subclk), .sysclk_taps(sysclk_taps), .subclk_taps(subclk_taps),
    .timer_overflow(timer_overflow), .overflow_request_flag(overflow_request_flag),
    .irq(irq));

`default_nettype wire

/* testbench/pait_timer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pait_regs.vh"

module pait_timer_tb;
    localparam [17:0] A_MODE = {`PAIT_IDX_MODE, 2'b00};
    localparam [17:0] A_CNT  = {`PAIT_IDX_COUNT, 2'b00};
    localparam [17:0] A_STS  = {`PAIT_IDX_STATUS, 2'b00};
    localparam [17:0] A_MSK  = {`PAIT_IDX_MASK, 2'b00};
    logic        ref_clk, nrst, hsel, hwrite, low_power_mode;
    logic        subclk = 1'b0;
    logic [17:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [2:0]  sdiv = 3'b000;
    logic [31:0] hwdata, hrdata, rd, c0;
    logic [12:0] sysclk_taps;
    logic [4:0]  subclk_taps;
    logic        hresp, timer_overflow, overflow_request_flag, irq, any;
    wire         hready;
    int          err_total = 0;
    int          n_compared = 0;
    int          div_s[8] = '{8192, 4096, 2048, 512, 256, 128, 32, 8};
    int          div_w[4] = '{256, 128, 64, 16};

    pait_timer dut (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .low_power_mode(low_power_mode),
        .subclk(subclk), .sysclk_taps(sysclk_taps), .subclk_taps(subclk_taps),
        .timer_overflow(timer_overflow), .overflow_request_flag(overflow_request_flag),
        .irq(irq));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // subclock one eighth of the bus clock, well under the synchroniser limit
    always @(posedge ref_clk) begin
        sdiv <= sdiv + 3'd1;
        subclk <= sdiv[2];
    end

    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    task automatic bus(input logic [17:0] a, input logic w, input logic [31:0] wd);
        @(posedge ref_clk);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        rd = hrdata;
    endtask

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic rd_chk(input logic [17:0] a, input logic [31:0] exp, input string what);
        bus(a, 1'b0, 32'h0000_0000);
        chk_word(what, exp, rd);
    endtask

    // two source periods between samples give exactly two counts, phase-free
    task automatic measure(input logic [31:0] mode, input int per, input string what);
        bus(A_MODE, 1'b1, mode);
        bus(A_CNT, 1'b0, 32'h0000_0000);
        c0 = rd;
        repeat (2 * per - 3) @(posedge ref_clk);
        rd_chk(A_CNT, (c0 + 32'd2) & 32'h0000_00ff, what);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rd_chk(A_MODE, 32'h0000_00f0, "mode reset");
        rd_chk(A_CNT, 32'h0000_0000, "count reset");
        rd_chk(A_STS, 32'h0000_0000, "status reset");
        rd_chk(A_MSK, 32'h0000_0000, "mask reset");
        bus(A_CNT, 1'b1, 32'h0000_00a5);
        rd_chk(A_CNT, 32'h0000_0000, "count read only");
        rd_chk(18'h0_0010, 32'h0000_0000, "unmapped read");
        chk_bit("irq reset", 1'b0, irq);
        $display("test reset done");
    endtask

    task automatic t_mode;
        for (int v = 0; v < 16; v++) begin
            bus(A_MODE, 1'b1, v);
            rd_chk(A_MODE, 32'h0000_00f0 | v, "mode write");
        end
        $display("test mode done");
    endtask

    task automatic t_interval;
        for (int s = 0; s < 8; s++)
            measure(s, div_s[s], "interval count");
        low_power_mode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        bus(A_CNT, 1'b0, 32'h0000_0000);
        c0 = rd;
        repeat (40) @(posedge ref_clk);
        rd_chk(A_CNT, c0, "count frozen in low power");
        low_power_mode <= 1'b0;
        measure(7, 8, "count after wake");
        $display("test interval done");
    endtask

    task automatic t_overflow;
        bus(A_MSK, 1'b1, 32'h0000_0001);
        bus(A_MODE, 1'b1, 32'h0000_0007);
        for (int i = 0; i < 2100 && irq !== 1'b1; i++) @(posedge ref_clk);
        chk_bit("irq on overflow", 1'b1, irq);
        chk_bit("request flag", 1'b1, overflow_request_flag);
        rd_chk(A_CNT, 32'h0000_0000, "count wrapped");
        bus(A_STS, 1'b1, 32'h0000_0001);
        rd_chk(A_STS, 32'h0000_0000, "status cleared");
        chk_bit("irq cleared", 1'b0, irq);
        bus(A_MSK, 1'b1, 32'h0000_0000);
        for (int i = 0; i < 2100 && overflow_request_flag !== 1'b1; i++) @(posedge ref_clk);
        chk_bit("masked flag", 1'b1, overflow_request_flag);
        chk_bit("masked irq", 1'b0, irq);
        bus(A_STS, 1'b1, 32'h0000_0001);
        $display("test overflow done");
    endtask

    task automatic t_timebase;
        bus(A_MODE, 1'b1, 32'h0000_000c);
        any = 1'b0;
        repeat (300) begin
            @(posedge ref_clk);
            any = any | (|subclk_taps);
        end
        chk_bit("subclock taps held", 1'b0, any);
        rd_chk(A_CNT, 32'h0000_0000, "count held");
        bus(A_MODE, 1'b1, 32'h0000_0008);
        rd_chk(A_CNT, 32'h0000_0000, "count resumes from zero");
        low_power_mode <= 1'b1;
        for (int s = 0; s < 4; s++)
            measure(32'h0000_0008 | s, div_w[s], "time base count");
        low_power_mode <= 1'b0;
        $display("test time base done");
    endtask

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge ref_clk);
        err_total++;
        $display("Error watchdog expected end seen timeout");
        results;
    end

    initial begin
        nrst = 1'b0; hsel = 1'b0; haddr = 18'h0_0000; htrans = 2'b00; hwrite = 1'b0;
        hsize = 3'b010; hwdata = 32'h0000_0000; low_power_mode = 1'b0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        t_reset;
        t_mode;
        t_interval;
        t_overflow;
        t_timebase;
        results;
    end
endmodule

`default_nettype wire
